// File: pkg/dsm_pkg.sv
// Constants and helpers for the DiffServ priority map
// How it works
// [R1] Lookup code is TOS byte bits 7:2
// [R2] Each of 64 codes owns a field
// [R3] Priority equals the selected stored field
// [R4] First register maps codes 00..0c, resets 00
// [R5] Offset 0x91 maps codes 10..1c
// [R6] Offset 0x92 maps codes 20..2c
// [R7] Offset 0x93 maps codes 30..3c
// [R8] Offset 0x94 maps codes 40..4c
// [R9] Same packing continues through later registers
// [R10] Table used only for enabled IP frames
package dsm_pkg;

   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 8;
   localparam int          PRIO_W       = 2;
   localparam int          CODE_W       = 6;
   localparam int          NUM_CODES    = 64;
   localparam int          FIELDS_PER_R = 4;
   localparam int          NUM_REGS     = NUM_CODES / FIELDS_PER_R;
   localparam int          TABLE_W      = NUM_CODES * PRIO_W;

   // Register offsets
   localparam logic [7:0]  MAP_00_0C    = 8'h90;
   localparam logic [7:0]  MAP_10_1C    = 8'h91;
   localparam logic [7:0]  MAP_20_2C    = 8'h92;
   localparam logic [7:0]  MAP_30_3C    = 8'h93;
   localparam logic [7:0]  MAP_40_4C    = 8'h94;
   localparam logic [7:0]  MAP_LAST     = 8'h9f;
   localparam logic [7:0]  LAST_RESULT  = 8'ha0;

   // Reset values
   localparam logic [7:0]  MAP_RESET    = 8'h00;
   localparam logic [7:0]  LAST_RESET   = 8'h00;

   // Last result register fields
   localparam int          LAST_CODE_LSB = 0;
   localparam int          LAST_PRIO_LSB = 6;

   // Code from the TOS or traffic class byte
   function automatic logic [5:0] code_of(input logic [7:0] tos);
      code_of = tos[7:2]; // [R1]
   endfunction

   // True when the address falls in the map
   function automatic logic is_map(input logic [7:0] addr);
      is_map = (addr >= MAP_00_0C) && (addr <= MAP_LAST);
   endfunction

endpackage

// File: verilog/dsm_lookup.sv
// Field selector of the fully decoded priority table
module dsm_lookup #(
   parameter int NUM_CODES = 64,
   parameter int PRIO_W    = 2
) (
   // Table contents
   input  wire logic [NUM_CODES*PRIO_W-1:0] table_flat,
   // Lookup
   input  wire logic [5:0]                  code,
   output logic      [PRIO_W-1:0]           prio
);

   // Each code has its own two bits, code n at bits 2n+1:2n
   assign prio = table_flat[code*PRIO_W +: PRIO_W]; // [R2] [R3]

endmodule

// File: verilog/dsm_priority_map.sv
// DiffServ codepoint to priority map with register port
module dsm_priority_map (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Frame classification request
   input  wire logic       cls_valid,
   input  wire logic       cls_is_ip,
   input  wire logic       cls_ds_en,
   input  wire logic [7:0] cls_tos,
   input  wire logic [1:0] cls_alt_prio,
   // Classification result
   output logic            res_valid,
   output logic      [1:0] res_prio,
   output logic            res_from_map
);

   logic [7:0]                     map_q [dsm_pkg::NUM_REGS];
   logic [dsm_pkg::TABLE_W-1:0]    table_flat;
   logic [1:0]                     map_prio;
   logic [5:0]                     code;
   logic                           use_map;
   logic [7:0]                     last_q;
   logic [7:0]                     rdata_q;
   logic                           res_valid_q;
   logic [1:0]                     res_prio_q;
   logic                           res_from_map_q;
   logic [3:0]                     widx;

   assign widx = reg_addr[3:0];

   // Register n holds codes 4n..4n+3, lowest code in bits 1:0
   always_comb begin
      for (int i = 0; i < dsm_pkg::NUM_REGS; i++) begin
         table_flat[i*8 +: 8] = map_q[i]; // [R4] [R5] [R6] [R7] [R8] [R9]
      end
   end

   // Map registers, all read/write, reset to zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < dsm_pkg::NUM_REGS; i++) begin
            map_q[i] <= dsm_pkg::MAP_RESET; // [R4]
         end
      end else if (reg_wr && dsm_pkg::is_map(reg_addr)) begin
         map_q[widx] <= reg_wdata; // [R4] [R5] [R6] [R7] [R8] [R9]
      end
   end

   assign code = dsm_pkg::code_of(cls_tos); // [R1]

   dsm_lookup #(
      .NUM_CODES (dsm_pkg::NUM_CODES),
      .PRIO_W    (dsm_pkg::PRIO_W)
   ) u_lookup (
      .table_flat (table_flat),
      .code       (code),
      .prio       (map_prio)
   );

   assign use_map = cls_is_ip && cls_ds_en; // [R10]

   // Registered classification result
   always_ff @(posedge core_clk) begin
      if (rst) begin
         res_valid_q    <= 1'b0;
         res_prio_q     <= 2'h0;
         res_from_map_q <= 1'b0;
      end else begin
         res_valid_q    <= cls_valid;
         if (cls_valid) begin
            res_prio_q     <= use_map ? map_prio : cls_alt_prio; // [R3] [R10]
            res_from_map_q <= use_map;
         end
      end
   end

   // Last table hit, code and priority
   always_ff @(posedge core_clk) begin
      if (rst) begin
         last_q <= dsm_pkg::LAST_RESET;
      end else if (cls_valid && use_map) begin
         last_q[dsm_pkg::LAST_CODE_LSB +: 6] <= code;
         last_q[dsm_pkg::LAST_PRIO_LSB +: 2] <= map_prio;
      end
   end

   // Read data for one cycle after the strobe, zero otherwise
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         if (dsm_pkg::is_map(reg_addr)) begin
            rdata_q <= map_q[widx];
         end else if (reg_addr == dsm_pkg::LAST_RESULT) begin
            rdata_q <= last_q;
         end else begin
            rdata_q <= 8'h00;
         end
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata    = rdata_q;
   assign res_valid    = res_valid_q;
   assign res_prio     = res_prio_q;
   assign res_from_map = res_from_map_q;

endmodule

// File: verification/dsm_chk.sv
// Port checker for the DiffServ priority map
module dsm_chk (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       cls_valid,
   input wire logic       cls_is_ip,
   input wire logic       cls_ds_en,
   input wire logic [7:0] cls_tos,
   input wire logic [1:0] cls_alt_prio,
   input wire logic       res_valid,
   input wire logic [1:0] res_prio,
   input wire logic       res_from_map
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire hit = cls_valid && cls_is_ip && cls_ds_en;
   AST_RES_VALID: assert property (res_valid == $past(cls_valid))
      else $error("result pulse timing");
   AST_FROM_MAP: assert property (cls_valid |=> res_from_map == $past(hit))
      else $error("table flag wrong");
   AST_ALT: assert property (cls_valid && !hit |=>
      res_prio == $past(cls_alt_prio)) else $error("fallback priority");
   AST_HOLD: assert property (!cls_valid |=> $stable(res_prio))
      else $error("priority changed without request");
   AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not cleared");
   AST_RD_BACK: assert property (reg_wr && reg_addr inside {[8'h90:8'h9f]}
      ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("readback wrong");
   AST_UNMAPPED: assert property (reg_rd && reg_addr < 8'h90 |=>
      reg_rdata == 8'h00) else $error("unmapped read not zero");
   AST_SAME: assert property (hit && !reg_wr ##1 !reg_wr ##1 hit &&
      cls_tos[7:2] == $past(cls_tos[7:2], 2) |=>
      res_prio == $past(res_prio, 2)) else $error("same code differs");
endmodule
bind dsm_priority_map dsm_chk chk_i (.*);

// File: verification/testbench.sv
// Self-checking bench for the DiffServ priority map
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       core_clk, rst, reg_wr, reg_rd, cls_valid, cls_is_ip;
   logic       cls_ds_en, res_valid, res_from_map;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, cls_tos;
   logic [1:0] cls_alt_prio, res_prio;
   int         n_fail, n_checks, cyc;
   dsm_priority_map dut (.*);
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic final_report();
      if (n_fail == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 1000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(logic [7:0] got, logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] pat(int n);
      return 8'(n * 8'h25 + 8'h1b);
   endfunction
   function automatic logic [1:0] ep(int c);
      return 2'(pat(c / 4) >> (2 * (c % 4)));
   endfunction
   task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 if (!w) chk(reg_rdata, d);
   endtask
   task automatic cls(logic [7:0] t, logic i, logic e, logic [1:0] a,
                      logic [1:0] p, logic m);
      @(posedge core_clk);
      cls_tos <= t;
      cls_is_ip <= i;
      cls_ds_en <= e;
      cls_alt_prio <= a;
      cls_valid <= 1'b1;
      @(posedge core_clk);
      cls_valid <= 1'b0;
      #1 chk(8'(res_valid), 8'h01);
      chk(8'(res_prio), 8'(p));
      chk(8'(res_from_map), 8'(m));
   endtask
   initial begin
      {rst, reg_wr, reg_rd, cls_valid, cls_is_ip, cls_ds_en} = 6'h20;
      {reg_addr, reg_wdata, cls_tos, cls_alt_prio} = 26'h0;
      {n_fail, n_checks, cyc} = '0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      for (int r = 0; r < 16; r++) acc(0, 8'(8'h90 + r), 8'h00);
      for (int r = 0; r < 16; r++) begin
         acc(1, 8'(8'h90 + r), pat(r));
         acc(0, 8'(8'h90 + r), pat(r));
      end
      for (int c = 0; c < 64; c++)
         cls({6'(c), 2'h3}, 1, 1, 2'h0, ep(c), 1);
      cls(8'hfc, 1, 1, 2'h3, ep(63), 1);
      cls(8'h14, 0, 1, 2'h2, 2'h2, 0);
      cls(8'h14, 1, 0, 2'h1, 2'h1, 0);
      acc(1, 8'ha0, 8'hff);
      acc(0, 8'ha0, {ep(63), 6'h3f});
      acc(0, 8'h00, 8'h00);
      final_report();
   end
endmodule
